/* File: sscr_pkg.sv */
// Constants, offsets and carrier types for the supply switch, regulator and random control block.
// Assumes an 8-bit register port on the CPU clock, one aligned byte per address.
package sscr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [15:0] SSCR_ADDR_RNG_DATA = 16'h6105;
  localparam logic [15:0] SSCR_ADDR_CTRL     = 16'h6106;
  localparam logic [15:0] SSCR_ADDR_REG      = 16'h6109;
  localparam logic [15:0] SSCR_ADDR_IRQ_STAT = 16'h6110;
  localparam logic [15:0] SSCR_ADDR_IRQ_EN   = 16'h6111;
  localparam logic [15:0] SSCR_ADDR_IRQ_CLR  = 16'h6112;

  // ==========================================================================
  // Secure supply and random control field positions
  localparam int SSCR_CTRL_MASK_BIT     = 6;
  localparam int SSCR_CTRL_OVERLOAD_BIT = 5;
  localparam int SSCR_CTRL_SUPPLY_BIT   = 4;
  localparam int SSCR_CTRL_FORCE_BIT    = 2;
  localparam int SSCR_CTRL_READY_BIT    = 1;
  localparam int SSCR_CTRL_FIXED_BIT    = 0;
  localparam logic [7:0] SSCR_CTRL_RESET = 8'h41;

  // ==========================================================================
  // Regulator control field positions
  localparam int SSCR_REG_OC_BIT     = 5;
  localparam int SSCR_REG_SEL_LSB    = 3;
  localparam int SSCR_REG_OFFSET_BIT = 2;
  localparam int SSCR_REG_SOFTBW_BIT = 1;
  localparam int SSCR_REG_BWSRC_BIT  = 0;
  localparam logic [7:0] SSCR_REG_RESET = 8'h04;

  // Overcurrent thresholds in mA, indexed by the two-bit select field.
  localparam int SSCR_OC_MA_SEL0 = 300;
  localparam int SSCR_OC_MA_SEL1 = 210;
  localparam int SSCR_OC_MA_SEL2 = 180;
  localparam int SSCR_OC_MA_SEL3 = 150;
  // Switch current limit in mA.
  localparam int SSCR_LIMIT_MA = 40;

  // ==========================================================================
  // Interrupt bits
  localparam int SSCR_IRQ_OC       = 0;
  localparam int SSCR_IRQ_OVERLOAD = 1;
  localparam int SSCR_IRQ_RNG      = 2;
  localparam int SSCR_IRQ_W        = 3;
  localparam logic [2:0] SSCR_IRQ_RESET = 3'h0;

  // Analog comparator outputs; oc_above[n] is high above threshold SEL n.
  typedef struct packed {
    logic [3:0] oc_above;
    logic       limiter_active;
    logic       rf_detected;
  } sscr_analog_t;

  // Raw pad levels of the secure-chip signal inputs.
  typedef struct packed {
    logic secure_signal;
    logic shared_port;
  } sscr_pads_t;

endpackage

/* File: sscr_sync.sv */
// Two-flip-flop synchroniser for independent single-bit levels.
// Assumes each bit is unrelated to the others; no word coherence is given.
`timescale 1ns/1ns
`default_nettype none
module sscr_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1)
  begin : g_check
    $error("sscr_sync needs WIDTH of at least one");
  end

  // ==========================================================================
  // Synchroniser chain
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

/* File: sscr_regs.sv */
// Control and status registers for the linear regulator, the secure-chip supply switch
// and the random generator handshake, with a small interrupt unit.
// Assumes analog comparator and pad levels are asynchronous; random data arrives on clock_in.
// Operation
// - Overcurrent flag sets when current passes the threshold chosen by select field.
// - Overcurrent reaches the interrupt only when its enable bit is one.
// - Offset enable resets to one; one keeps offset, zero removes it.
// - Software bandwidth bit: zero reduced bandwidth, one increased bandwidth.
// - Source bit one follows software bit; zero follows RF detector, reduced on field.
// - Supply enable zero grounds secure supply; one powers chip and pads.
// - Overload status bit is high while the 40 mA limiter is active.
// - Mask bit, reset one, holds signal input zero and port input one.
// - Force bit one runs the generator continuously; zero leaves contactless unit control.
// - Ready flag sets when a new random number is available.
// - Reading the random data register clears the ready flag.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module sscr_regs
  import sscr_pkg::*;
(
  input  wire logic         clock_in,
  input  wire logic         sys_rst_in,
  input  wire logic [15:0]  addr_in,
  input  wire logic [7:0]   wr_data_in,
  input  wire logic         wr_en_in,
  input  wire logic         rd_en_in,
  output logic      [7:0]   rd_data_out,
  input  wire sscr_analog_t analog_in,
  input  wire sscr_pads_t   pads_in,
  input  wire logic         rng_valid_in,
  input  wire logic [7:0]   rng_data_in,
  output logic              regulator_offset_en_out,
  output logic              regulator_high_bw_out,
  output logic              secure_supply_en_out,
  output logic              rng_force_run_out,
  output logic              secure_signal_input_out,
  output logic              shared_port_input_out,
  output logic              irq_out
);

  // ==========================================================================
  // Synchronised inputs
  sscr_analog_t analog_s;
  sscr_pads_t   pads_s;

  sscr_sync #(
    .WIDTH ($bits(sscr_analog_t) + $bits(sscr_pads_t))
  ) u_sync (
    .clock_in   (clock_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({analog_in, pads_in}),
    .sync_out   ({analog_s, pads_s})
  );

  // ==========================================================================
  // State
  logic [1:0]          oc_sel;
  logic                offset_en;
  logic                soft_bw;
  logic                bw_src;
  logic                oc_status;
  logic                mask_inputs;
  logic                supply_en;
  logic                force_rng;
  logic                rng_ready;
  logic [7:0]          rng_data;
  logic                overload_q;
  logic [SSCR_IRQ_W-1:0] irq_stat;
  logic [SSCR_IRQ_W-1:0] irq_en;
  logic [7:0]          next_rd_data;

  logic wr_ctrl;
  logic wr_reg;
  logic rd_rng;
  logic oc_detect;
  logic [SSCR_IRQ_W-1:0] irq_set;

  assign wr_ctrl = wr_en_in && (addr_in == SSCR_ADDR_CTRL);
  assign wr_reg  = wr_en_in && (addr_in == SSCR_ADDR_REG);
  assign rd_rng  = rd_en_in && (addr_in == SSCR_ADDR_RNG_DATA);

  assign oc_detect = analog_s.oc_above[oc_sel];

  // ==========================================================================
  // Regulator control register
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      oc_sel    <= SSCR_REG_RESET[SSCR_REG_SEL_LSB +: 2];
      offset_en <= SSCR_REG_RESET[SSCR_REG_OFFSET_BIT];
      soft_bw   <= SSCR_REG_RESET[SSCR_REG_SOFTBW_BIT];
      bw_src    <= SSCR_REG_RESET[SSCR_REG_BWSRC_BIT];
    end
    else if (wr_reg)
    begin
      oc_sel    <= wr_data_in[SSCR_REG_SEL_LSB +: 2];
      offset_en <= wr_data_in[SSCR_REG_OFFSET_BIT];
      soft_bw   <= wr_data_in[SSCR_REG_SOFTBW_BIT];
      bw_src    <= wr_data_in[SSCR_REG_BWSRC_BIT];
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      oc_status <= SSCR_REG_RESET[SSCR_REG_OC_BIT];
    else if (oc_detect)
      oc_status <= 1'b1;
  end

  // ==========================================================================
  // Secure supply and random control register
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      mask_inputs <= SSCR_CTRL_RESET[SSCR_CTRL_MASK_BIT];
      supply_en   <= SSCR_CTRL_RESET[SSCR_CTRL_SUPPLY_BIT];
      force_rng   <= SSCR_CTRL_RESET[SSCR_CTRL_FORCE_BIT];
    end
    else if (wr_ctrl)
    begin
      mask_inputs <= wr_data_in[SSCR_CTRL_MASK_BIT];
      supply_en   <= wr_data_in[SSCR_CTRL_SUPPLY_BIT];
      force_rng   <= wr_data_in[SSCR_CTRL_FORCE_BIT];
    end
  end

  // New data beats a read clear or a software write in the same cycle.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rng_ready <= SSCR_CTRL_RESET[SSCR_CTRL_READY_BIT];
    else if (rng_valid_in)
      rng_ready <= 1'b1;
    else if (rd_rng)
      rng_ready <= 1'b0;
    else if (wr_ctrl)
      rng_ready <= wr_data_in[SSCR_CTRL_READY_BIT];
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rng_data <= 8'h00;
    else if (rng_valid_in)
      rng_data <= rng_data_in;
  end

  // ==========================================================================
  // Interrupt unit
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      overload_q <= 1'b0;
    else
      overload_q <= analog_s.limiter_active;
  end

  always_comb
  begin
    irq_set                    = '0;
    irq_set[SSCR_IRQ_OC]       = oc_detect && !oc_status;
    irq_set[SSCR_IRQ_OVERLOAD] = analog_s.limiter_active && !overload_q;
    irq_set[SSCR_IRQ_RNG]      = rng_valid_in;
  end

  // A status bit set in the same cycle as its clear stays set.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      irq_stat <= SSCR_IRQ_RESET;
    else if (wr_en_in && (addr_in == SSCR_ADDR_IRQ_CLR))
      irq_stat <= (irq_stat & ~wr_data_in[SSCR_IRQ_W-1:0]) | irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      irq_en <= SSCR_IRQ_RESET;
    else if (wr_en_in && (addr_in == SSCR_ADDR_IRQ_EN))
      irq_en <= wr_data_in[SSCR_IRQ_W-1:0];
  end

  assign irq_out = |(irq_stat & irq_en);

  // ==========================================================================
  // Read port
  always_comb
  begin
    next_rd_data = 8'h00;
    if (rd_en_in)
    begin
      unique case (addr_in)
        SSCR_ADDR_RNG_DATA:
          next_rd_data = rng_data;
        SSCR_ADDR_CTRL:
        begin
          next_rd_data[SSCR_CTRL_MASK_BIT]     = mask_inputs;
          next_rd_data[SSCR_CTRL_OVERLOAD_BIT] = analog_s.limiter_active;
          next_rd_data[SSCR_CTRL_SUPPLY_BIT]   = supply_en;
          next_rd_data[SSCR_CTRL_FORCE_BIT]    = force_rng;
          next_rd_data[SSCR_CTRL_READY_BIT]    = rng_ready;
          next_rd_data[SSCR_CTRL_FIXED_BIT]    = SSCR_CTRL_RESET[SSCR_CTRL_FIXED_BIT];
        end
        SSCR_ADDR_REG:
        begin
          next_rd_data[SSCR_REG_OC_BIT]         = oc_status;
          next_rd_data[SSCR_REG_SEL_LSB +: 2]   = oc_sel;
          next_rd_data[SSCR_REG_OFFSET_BIT]     = offset_en;
          next_rd_data[SSCR_REG_SOFTBW_BIT]     = soft_bw;
          next_rd_data[SSCR_REG_BWSRC_BIT]      = bw_src;
        end
        SSCR_ADDR_IRQ_STAT:
          next_rd_data[SSCR_IRQ_W-1:0] = irq_stat;
        SSCR_ADDR_IRQ_EN:
          next_rd_data[SSCR_IRQ_W-1:0] = irq_en;
        default:
          next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
      rd_data_out <= 8'h00;
    else
      rd_data_out <= next_rd_data;
  end

  // ==========================================================================
  // Analog and pad controls
  // offset enable drive
  assign regulator_offset_en_out = offset_en;
  assign regulator_high_bw_out   = bw_src ? soft_bw : !analog_s.rf_detected;
  assign secure_supply_en_out    = supply_en;
  assign rng_force_run_out       = force_rng;
  assign secure_signal_input_out = mask_inputs ? 1'b0 : pads_s.secure_signal;
  assign shared_port_input_out   = mask_inputs ? 1'b1 : pads_s.shared_port;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_read_ctrl;
    rd_en_in && (addr_in == SSCR_ADDR_CTRL);
  endsequence

  sequence s_write_reg_soft_fast;
    wr_reg && wr_data_in[SSCR_REG_BWSRC_BIT] && wr_data_in[SSCR_REG_SOFTBW_BIT];
  endsequence

  property p_oc_set;
    oc_detect |=> oc_status;
  endproperty
  a_oc_set: assert property (p_oc_set) else $error("overcurrent flag not set");

  property p_oc_irq;
    (oc_detect && !oc_status && irq_en[SSCR_IRQ_OC]
      && !(wr_en_in && addr_in == SSCR_ADDR_IRQ_EN)) |=> irq_out;
  endproperty
  a_oc_irq: assert property (p_oc_irq) else $error("overcurrent irq missing");

  property p_offset_reset;
    $fell(sys_rst_in) |-> regulator_offset_en_out;
  endproperty
  a_offset_reset: assert property (@(posedge clock_in) p_offset_reset)
    else $error("offset enable not one after reset");

  property p_soft_bw;
    s_write_reg_soft_fast |=> regulator_high_bw_out;
  endproperty
  a_soft_bw: assert property (p_soft_bw) else $error("software bandwidth ignored");

  property p_rf_bw;
    (wr_reg && !wr_data_in[SSCR_REG_BWSRC_BIT])
      |=> regulator_high_bw_out == !analog_s.rf_detected;
  endproperty
  a_rf_bw: assert property (p_rf_bw) else $error("rf bandwidth source ignored");

  property p_supply_off;
    (wr_ctrl && !wr_data_in[SSCR_CTRL_SUPPLY_BIT]) |=> !secure_supply_en_out;
  endproperty
  a_supply_off: assert property (p_supply_off) else $error("supply not off");

  property p_overload_read;
    s_read_ctrl ##1 1'b1 |-> rd_data_out[SSCR_CTRL_OVERLOAD_BIT]
      == $past(analog_s.limiter_active);
  endproperty
  a_overload_read: assert property (p_overload_read) else $error("overload bit wrong");

  property p_mask;
    (wr_ctrl && wr_data_in[SSCR_CTRL_MASK_BIT])
      |=> !secure_signal_input_out && shared_port_input_out;
  endproperty
  a_mask: assert property (p_mask) else $error("masked inputs not held");

  property p_force;
    (wr_ctrl && wr_data_in[SSCR_CTRL_FORCE_BIT]) |=> rng_force_run_out;
  endproperty
  a_force: assert property (p_force) else $error("generator not forced");

  property p_ready_set;
    rng_valid_in |=> rng_ready;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  property p_ready_clear;
    (rd_rng && !rng_valid_in) |=> !rng_ready;
  endproperty
  a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared");

  property p_oc_sticky;
    oc_status |=> oc_status;
  endproperty
  a_oc_sticky: assert property (p_oc_sticky) else $error("overcurrent flag dropped");

endmodule
`default_nettype wire

/* File: sscr_regs_tb.sv */
// Self-checking bench for the regulator, secure supply switch and random control registers.
// Assumes the register block alone, driven through its byte register port on one clock.
`timescale 1ns/1ns
`default_nettype none
module sscr_regs_tb
  import sscr_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic [7:0]  rd;
    logic [5:0]  outs;
  } sscr_row_t;

  logic         clock_in;
  logic         sys_rst_in;
  logic [15:0]  addr;
  logic [7:0]   wr_data;
  logic         wr_en;
  logic         rd_en;
  logic [7:0]   rd_data;
  sscr_analog_t analog;
  sscr_pads_t   pads;
  logic         rng_valid;
  logic [7:0]   rng_data;
  logic         offset_en;
  logic         high_bw;
  logic         supply_en;
  logic         force_run;
  logic         sig_in;
  logic         port_in;
  logic         irq;
  wire logic [5:0] obs;
  logic [7:0]   got;
  int           errors;
  int           compares;
  int           i;

  // Outputs are packed as offset, bandwidth, supply, force, signal input, port input.
  // Pads sit at signal 1 and port 0 so that masking shows at the outputs.
  sscr_row_t rows [11] = '{
    '{16'h6109, 8'h00, 8'h00, 6'h11},
    '{16'h6109, 8'h07, 8'h07, 6'h31},
    '{16'h6109, 8'h05, 8'h05, 6'h21},
    '{16'h6109, 8'h18, 8'h18, 6'h11},
    '{16'h6106, 8'h14, 8'h15, 6'h1E},
    '{16'h6106, 8'hFF, 8'h57, 6'h1D},
    '{16'h6106, 8'h00, 8'h01, 6'h12},
    '{16'h6107, 8'hFF, 8'h00, 6'h12},
    '{16'h6111, 8'h07, 8'h07, 6'h12},
    '{16'h6112, 8'hFF, 8'h00, 6'h12},
    '{16'h6110, 8'hFF, 8'h00, 6'h12}
  };

  assign obs = {offset_en, high_bw, supply_en, force_run, sig_in, port_in};

  sscr_regs sscr_regs_i (
    .clock_in                (clock_in),
    .sys_rst_in              (sys_rst_in),
    .addr_in                 (addr),
    .wr_data_in              (wr_data),
    .wr_en_in                (wr_en),
    .rd_en_in                (rd_en),
    .rd_data_out             (rd_data),
    .analog_in               (analog),
    .pads_in                 (pads),
    .rng_valid_in            (rng_valid),
    .rng_data_in             (rng_data),
    .regulator_offset_en_out (offset_en),
    .regulator_high_bw_out   (high_bw),
    .secure_supply_en_out    (supply_en),
    .rng_force_run_out       (force_run),
    .secure_signal_input_out (sig_in),
    .shared_port_input_out   (port_in),
    .irq_out                 (irq)
  );

  always #25 clock_in = ~clock_in;

  // ==========================================================================
  // Bus cycles and comparisons
  task automatic summarize();
    $display("Counts: %0d compares, %0d errors", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock_in);
    wr_en   <= 1'b0;
    @(negedge clock_in);
  endtask

  task automatic rdchk(input string name, input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock_in);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock_in);
    rd_en <= 1'b0;
    @(negedge clock_in);
    chk(name, exp, rd_data);
  endtask

  task automatic do_reset(input int cycles);
    @(posedge clock_in);
    sys_rst_in <= 1'b1;
    repeat (cycles) @(posedge clock_in);
    sys_rst_in <= 1'b0;
    @(negedge clock_in);
    chk("reset outputs", 8'h31, {2'h0, obs});  // reset levels
    chk("reset irq", 8'h00, {7'h0, irq});  // nothing enabled after reset
    rdchk("ctrl reset", SSCR_ADDR_CTRL, 8'h41);  // mask resets to one
    rdchk("regulator reset", SSCR_ADDR_REG, 8'h04);  // offset set, flag cleared
    rdchk("status reset", SSCR_ADDR_IRQ_STAT, 8'h00);  // no events pending
    $display("reset test done");
  endtask

  // ==========================================================================
  // Watchdog
  initial
  begin
    repeat (6000) @(posedge clock_in);
    errors++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    clock_in = 1'b0;
    sys_rst_in = 1'b1;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    analog = '0;
    pads.secure_signal = 1'b1;
    pads.shared_port = 1'b0;
    rng_valid = 1'b0;
    rng_data = 8'h00;
    errors = 0;
    compares = 0;
    do_reset(20);
    // Back-to-back reads, then the data bus returns to zero.
    @(posedge clock_in);
    addr  <= SSCR_ADDR_CTRL;
    rd_en <= 1'b1;
    @(posedge clock_in);
    addr  <= SSCR_ADDR_REG;
    @(negedge clock_in);
    chk("first of two reads", 8'h41, rd_data);  // mask reads one
    @(posedge clock_in);
    rd_en <= 1'b0;
    @(negedge clock_in);
    chk("second of two reads", 8'h04, rd_data);  // offset bit reads one
    @(negedge clock_in);
    chk("idle read data", 8'h00, rd_data);
    $display("back-to-back read test done");

    for (i = 0; i < 11; i++)
    begin
      wr(rows[i].addr, rows[i].data);
      chk("outputs", {2'h0, rows[i].outs}, {2'h0, obs});  // fields drive pins
      rdchk("readback", rows[i].addr, rows[i].rd);  // stored fields and fixed bits
    end
    chk("irq idle", 8'h00, {7'h0, irq});  // enabled but no event
    $display("table test done");

    @(posedge clock_in);
    rng_valid <= 1'b1;
    rng_data  <= 8'hA5;
    @(posedge clock_in);
    rng_valid <= 1'b0;
    @(negedge clock_in);
    chk("irq on random", 8'h01, {7'h0, irq});  // new data raises event
    rdchk("ready set", SSCR_ADDR_CTRL, 8'h03);  // ready flag set
    rdchk("random status", SSCR_ADDR_IRQ_STAT, 8'h04);  // event recorded
    rdchk("random data", SSCR_ADDR_RNG_DATA, 8'hA5);  // byte readable
    rdchk("ready cleared", SSCR_ADDR_CTRL, 8'h01);  // read clears ready
    wr(SSCR_ADDR_IRQ_CLR, 8'h04);
    chk("irq cleared", 8'h00, {7'h0, irq});  // cleared event drops irq
    $display("random test done");

    wr(SSCR_ADDR_REG, 8'h10);
    @(posedge clock_in);
    analog.oc_above <= 4'h8;
    repeat (5) @(posedge clock_in);
    rdchk("below threshold", SSCR_ADDR_REG, 8'h10);  // other thresholds ignored
    @(posedge clock_in);
    analog.oc_above <= 4'hC;
    repeat (5) @(posedge clock_in);
    analog.oc_above <= 4'h0;
    repeat (5) @(posedge clock_in);
    rdchk("overcurrent sticky", SSCR_ADDR_REG, 8'h30);  // flag set and held
    chk("irq overcurrent", 8'h01, {7'h0, irq});  // enabled event reaches irq
    wr(SSCR_ADDR_IRQ_EN, 8'h06);
    chk("irq masked", 8'h00, {7'h0, irq});  // disabled event is held back
    wr(SSCR_ADDR_IRQ_EN, 8'h07);
    wr(SSCR_ADDR_IRQ_CLR, 8'h01);
    wr(SSCR_ADDR_REG, 8'h00);
    rdchk("flag read only", SSCR_ADDR_REG, 8'h20);  // software cannot clear flag
    $display("overcurrent test done");

    @(posedge clock_in);
    analog.limiter_active <= 1'b1;
    repeat (5) @(posedge clock_in);
    rdchk("overload live", SSCR_ADDR_CTRL, 8'h21);  // limiter shows in status bit
    chk("irq overload", 8'h01, {7'h0, irq});  // limiter event raises irq
    @(posedge clock_in);
    analog.limiter_active <= 1'b0;
    repeat (5) @(posedge clock_in);
    rdchk("overload gone", SSCR_ADDR_CTRL, 8'h01);  // bit follows limiter
    wr(SSCR_ADDR_IRQ_CLR, 8'h02);
    $display("overload test done");

    @(posedge clock_in);
    analog.rf_detected <= 1'b1;
    repeat (5) @(posedge clock_in);
    @(negedge clock_in);
    chk("bandwidth on field", 8'h00, {7'h0, high_bw});  // field reduces bandwidth
    wr(SSCR_ADDR_REG, 8'h03);
    chk("software high", 8'h01, {7'h0, high_bw});  // software bit selected
    wr(SSCR_ADDR_REG, 8'h01);
    chk("software low", 8'h00, {7'h0, high_bw});  // zero reduces bandwidth
    $display("bandwidth test done");

    do_reset(4);
    @(posedge clock_in);
    analog.oc_above <= 4'hE;
    repeat (5) @(posedge clock_in);
    rdchk("300 mA not reached", SSCR_ADDR_REG, 8'h04);  // select zero uses top threshold
    @(posedge clock_in);
    analog.oc_above <= 4'hF;
    repeat (5) @(posedge clock_in);
    rdchk("300 mA exceeded", SSCR_ADDR_REG, 8'h24);  // flag set at select zero
    $display("threshold zero test done");
    summarize();
  end
endmodule
`default_nettype wire
